// ===== smf_pkg.sv
// Shared constants, types and helpers of the serial master
package smf_pkg;
	localparam logic [7:0] ADDR_CFG_MAIN = 8'hfc;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hfd;
	localparam logic [7:0] ADDR_FLAGS = 8'hfe;
	localparam logic [7:0] ADDR_DATA = 8'hff;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 2;
	localparam logic [6:0] CFG_MAIN_RESET = 7'h20;
	localparam logic [3:0] IRQ_MASK_RESET = 4'hf;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [2:0] DIV_SEL_MAX = 3'h5;
	localparam logic [4:0] EDGE_LAST = 5'h0f;
	localparam int CLK_PERIOD_NS = 50;

	// Field layout follows the register: bits 6:4, 3, 2, 1, 0
	typedef struct packed {
		logic [2:0] sclk_divider_select;
		logic bit_order_select;
		logic sclk_idle_level;
		logic sample_edge_select;
		logic master_core_on;
	} smf_cfg_t;

	// Bits 3 down to 0 of the status register
	typedef struct packed {
		logic rx_full_flag;
		logic rx_avail_flag;
		logic tx_empty_flag;
		logic tx_space_flag;
	} smf_flags_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} smf_sfr_req_t;

	typedef enum logic [1:0] {
		SMF_IDLE,
		SMF_SHIFT,
		SMF_DONE
	} smf_state_t;

	// Codes above the largest divider fold onto it
	function automatic logic [2:0] smf_div_cap(input logic [2:0] sel);
		return (sel > DIV_SEL_MAX) ? DIV_SEL_MAX : sel;
	endfunction
endpackage

// ===== smf_clkdiv.sv
// Half-period tick generator for the serial clock
`timescale 1ns/10ps
module smf_clkdiv
	import smf_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic hold,
	input wire logic [2:0] div_sel,
	output logic tick
);
	logic [5:0] count;
	logic [5:0] next_count;
	logic [5:0] half_last;

	always_comb
	begin
		half_last = 6'((7'h01 << smf_div_cap(div_sel)) - 7'h01);
		next_count = 6'h00;
		tick = 1'b0;
		if (hold)
		begin
			// Stopped core keeps its phase
			next_count = count;
		end
		else if (run)
		begin
			if (count >= half_last)
			begin
				tick = 1'b1;
			end
			else
			begin
				next_count = 6'(count + 6'h01);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count <= 6'h00;
		end
		else
		begin
			count <= next_count;
		end
	end

	tick_spacing_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && run && !hold && smf_div_cap(div_sel) != 3'h0) |=> !tick)
		else $error("Serial clock tick came too soon");
endmodule

// ===== smf_fifo2.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module smf_fifo2
	import smf_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PW:0] next_count;
	logic push, pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	always_comb
	begin
		in_ready = (count != FULL);
		out_valid = (count != '0);
		out_data = mem[rd_ptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_mem = mem;
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_count = (PW+1)'(count + {PW'(0), push} - {PW'(0), pop});
		if (push)
		begin
			next_mem[wr_ptr] = in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem <= '{default: '0};
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	full_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
		(count == FULL && in_valid && !out_ready) |=> (count == FULL && $stable(out_data)))
		else $error("Full buffer took a word");
endmodule

// ===== smf_top.sv
// Serial master with register port, byte buffers and shift engine
// Functional notes
// - Enable bit 0 of main config lets the core run and start transfers.
// - Enable cleared freezes the core; no transfer advances.
// - Divider field 6:4, reset 010, selects clock/2..64; 110, 111 give 64.
// - Bit 3 set shifts least significant bit first, else most significant.
// - Bit 2 set makes serial clock idle high, else idle low.
// - Bit 1 set samples on trailing edge, shifts on leading; cleared reverses.
// - Polarity and phase reset to zero, mode 0; all four modes selectable.
// - Processor writes bytes to the enabled master, which sends them.
// - Data port writes fill two-byte send buffer, reads drain receive buffer.
// - Status flags follow their conditions live; no clearing action needed.
// - Receive-full flag, bit 3, set while two bytes are held.
// - Receive-available flag, bit 2, set while at least one byte held.
// - Send-empty flag, bit 1, set when send buffer empty; maskable interrupt.
// - Send-space flag, bit 0, set while a send entry is free.
// - Each status raises interrupt only while its mask bit is zero.
// - Mask register resets to all four bits set.
`timescale 1ns/10ps
module smf_top
	import smf_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	output logic IRQ,
	output logic MASTER_SERIAL_CLOCK,
	output logic MASTER_SERIAL_OUT,
	input wire logic MASTER_SERIAL_IN
);
	smf_sfr_req_t req;
	smf_cfg_t cfg, next_cfg;
	logic [3:0] mask, next_mask;
	logic [7:0] next_rdata;
	smf_flags_t flags;
	logic cfg_touched, next_cfg_touched;

	smf_state_t state, next_state;
	logic [4:0] edge_cnt, next_edge_cnt;
	logic [7:0] tx_sh, next_tx_sh;
	logic [7:0] rx_sh, next_rx_sh;
	logic sck_act, next_sck_act;
	logic mosi, next_mosi;
	logic tick;

	logic tx_in_valid, tx_in_ready, tx_out_valid, tx_pop;
	logic [7:0] tx_out_data;
	logic [1:0] tx_count;
	logic rx_in_ready, rx_out_valid, rx_push, rx_pop;
	logic [7:0] rx_out_data;
	logic [1:0] rx_count;

	function automatic logic hit(input smf_sfr_req_t r, input logic [7:0] a);
		return r.addr == a;
	endfunction

	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		return lsb ? sh[0] : sh[7];
	endfunction

	function automatic logic [7:0] advance(input logic [7:0] sh, input logic lsb);
		return lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
	endfunction

	assign req = '{addr: SFR_ADDR, wdata: SFR_WDATA, wr: SFR_WR, rd: SFR_RD};

	// Register port
	always_comb
	begin
		next_cfg = cfg;
		next_mask = mask;
		next_rdata = SFR_RDATA;
		next_cfg_touched = cfg_touched;
		tx_in_valid = req.wr && hit(req, ADDR_DATA);
		rx_pop = req.rd && hit(req, ADDR_DATA);
		if (req.wr && hit(req, ADDR_CFG_MAIN))
		begin
			next_cfg = smf_cfg_t'(req.wdata[6:0]);
			next_cfg_touched = 1'b1;
		end
		if (req.wr && hit(req, ADDR_IRQ_MASK))
		begin
			next_mask = req.wdata[3:0];
		end
		if (req.rd)
		begin
			case (req.addr)
				ADDR_CFG_MAIN: next_rdata = {1'b0, cfg};
				ADDR_IRQ_MASK: next_rdata = {4'h0, mask};
				ADDR_FLAGS: next_rdata = {4'h0, flags};
				// Empty buffer reads as zero and pops nothing
				ADDR_DATA: next_rdata = rx_out_valid ? rx_out_data : RDATA_RESET;
				default: next_rdata = RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cfg <= smf_cfg_t'(CFG_MAIN_RESET);
			mask <= IRQ_MASK_RESET;
			SFR_RDATA <= RDATA_RESET;
			cfg_touched <= 1'b0;
		end
		else
		begin
			cfg <= next_cfg;
			mask <= next_mask;
			SFR_RDATA <= next_rdata;
			cfg_touched <= next_cfg_touched;
		end
	end

	// Status is pure decode of buffer levels, so it never needs clearing
	always_comb
	begin
		flags.rx_full_flag = (rx_count == 2'(FIFO_DEPTH));
		flags.rx_avail_flag = (rx_count != 2'h0);
		flags.tx_empty_flag = (tx_count == 2'h0);
		flags.tx_space_flag = tx_in_ready;
		IRQ = |(flags & ~mask);
	end

	smf_fifo2 #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.in_valid(tx_in_valid),
		.in_ready(tx_in_ready),
		.in_data(req.wdata),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data),
		.count(tx_count)
	);

	smf_fifo2 #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data(rx_sh),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data),
		.count(rx_count)
	);

	smf_clkdiv u_div (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.run(state == SMF_SHIFT),
		.hold(!cfg.master_core_on),
		.div_sel(cfg.sclk_divider_select),
		.tick(tick)
	);

	// Shift engine; a disabled core simply takes no step, like a gated clock
	always_comb
	begin
		next_state = state;
		next_edge_cnt = edge_cnt;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_sck_act = sck_act;
		next_mosi = mosi;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		if (cfg.master_core_on)
		begin
			case (state)
				SMF_IDLE:
				begin
					// Room for the answer is checked first, so no byte is lost
					if (tx_out_valid && rx_in_ready)
					begin
						tx_pop = 1'b1;
						next_sck_act = 1'b0;
						next_edge_cnt = 5'h00;
						next_rx_sh = 8'h00;
						next_state = SMF_SHIFT;
						next_tx_sh = tx_out_data;
						if (!cfg.sample_edge_select)
						begin
							next_mosi = out_bit(tx_out_data, cfg.bit_order_select);
							next_tx_sh = advance(tx_out_data, cfg.bit_order_select);
						end
					end
				end
				SMF_SHIFT:
				begin
					if (tick)
					begin
						next_sck_act = !sck_act;
						next_edge_cnt = 5'(edge_cnt + 5'h01);
						if (sck_act == cfg.sample_edge_select)
						begin
							next_rx_sh = cfg.bit_order_select
								? {MASTER_SERIAL_IN, rx_sh[7:1]}
								: {rx_sh[6:0], MASTER_SERIAL_IN};
						end
						else if (edge_cnt != EDGE_LAST)
						begin
							next_mosi = out_bit(tx_sh, cfg.bit_order_select);
							next_tx_sh = advance(tx_sh, cfg.bit_order_select);
						end
						if (edge_cnt == EDGE_LAST)
						begin
							next_state = SMF_DONE;
						end
					end
				end
				SMF_DONE:
				begin
					rx_push = 1'b1;
					next_state = SMF_IDLE;
				end
				default: next_state = SMF_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state <= SMF_IDLE;
			edge_cnt <= 5'h00;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			sck_act <= 1'b0;
			mosi <= 1'b0;
		end
		else
		begin
			state <= next_state;
			edge_cnt <= next_edge_cnt;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			sck_act <= next_sck_act;
			mosi <= next_mosi;
		end
	end

	assign MASTER_SERIAL_CLOCK = cfg.sclk_idle_level ^ sck_act;
	assign MASTER_SERIAL_OUT = mosi;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);

	idle_clock_level_a: assert property (
		state == SMF_IDLE |-> MASTER_SERIAL_CLOCK == cfg.sclk_idle_level)
		else $error("Serial clock not at idle level");

	mode_zero_default_a: assert property (
		!cfg_touched |-> (!cfg.sclk_idle_level && !cfg.sample_edge_select
			&& cfg.sclk_divider_select == 3'h2 && !cfg.master_core_on))
		else $error("Config left its reset value untouched yet differs");

	frozen_core_a: assert property (
		(!cfg.master_core_on && !$past(req.wr)) |=> ($stable(edge_cnt) && $stable(sck_act)
			&& $stable(state)))
		else $error("Disabled core moved");

	start_pops_tx_a: assert property (
		(cfg.master_core_on && state == SMF_IDLE && tx_out_valid && rx_in_ready
			&& !tx_in_valid) |=> (state == SMF_SHIFT && tx_count == $past(tx_count) - 2'h1))
		else $error("Idle core did not start on queued byte");

	byte_capture_a: assert property (
		(cfg.master_core_on && state == SMF_SHIFT && tick && edge_cnt == EDGE_LAST)
			|=> (state == SMF_DONE) ##1 (state == SMF_IDLE && rx_count != 2'h0))
		else $error("Finished byte not pushed to receive buffer");

	masked_quiet_a: assert property (
		mask == 4'hf |-> !IRQ)
		else $error("Masked status raised interrupt");

	status_read_a: assert property (
		(req.rd && hit(req, ADDR_FLAGS)) |=> (SFR_RDATA[3] == ($past(rx_count) == 2'h2)
			&& SFR_RDATA[0] == ($past(tx_count) != 2'h2)))
		else $error("Status read disagrees with buffer levels");

	full_write_drop_a: assert property (
		(tx_in_valid && tx_count == 2'h2 && !tx_pop) |=> tx_count == 2'h2)
		else $error("Write into full send buffer changed it");

	rx_full_wait_a: assert property (
		(state == SMF_IDLE && rx_count == 2'h2) |=> state == SMF_IDLE)
		else $error("Transfer started with receive buffer full");

	out_steady_a: assert property (
		(state == SMF_SHIFT && !tick) |=> $stable(MASTER_SERIAL_OUT))
		else $error("Serial output moved between clock edges");
endmodule

// ===== smf_slave_model.sv
// Behavioural serial slave that answers the master in any of the four modes
`timescale 1ns/10ps
module smf_slave_model
	import smf_pkg::*;
(
	input wire logic clk,
	input wire logic sel,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb,
	input wire logic [7:0] tx_byte,
	input wire logic master_serial_clock,
	input wire logic master_serial_out,
	output logic master_serial_in,
	output logic [7:0] rx_byte
);
	int k;

	function automatic int pos(input int n);
		return lsb ? n % 8 : 7 - n % 8;
	endfunction

	// Second byte of a frame answers inverted, so buffer order shows
	function automatic logic out_at(input int n);
		logic [7:0] v;
		v = ((n / 8) % 2 == 1) ? ~tx_byte : tx_byte;
		return v[pos(n)];
	endfunction

	initial master_serial_in = 1'b0;

	// Released line toggles so a stale bit can never pass for data
	always @(posedge clk)
	begin
		if (!sel)
			master_serial_in <= ~master_serial_in;
	end

	// Software-driven select, not the master, frames the slave
	always @(posedge sel)
	begin
		k = 0;
		master_serial_in = out_at(0);
	end

	// Leading edge is the move away from the idle level
	always @(master_serial_clock)
	begin
		if (sel)
		begin
			if ((master_serial_clock != cpol) ^ cpha)
			begin
				rx_byte[pos(k)] = master_serial_out;
				if (cpha)
					k++;
			end
			else
			begin
				if (!cpha)
					k++;
				master_serial_in = out_at(k);
			end
		end
	end
endmodule

// ===== smf_top_tb.sv
// Self-checking bench of the serial master against a slave model
`timescale 1ns/10ps
module smf_top_tb
	import smf_pkg::*;
;
	logic CLK_SYS = 1'b0;
	logic RESET_N = 1'b0;
	logic SFR_WR = 1'b0;
	logic SFR_RD = 1'b0;
	logic sel = 1'b0;
	logic [7:0] SFR_ADDR = 8'h00;
	logic [7:0] SFR_WDATA = 8'h00;
	logic [7:0] SFR_RDATA, q, sb, b0, b1, srx;
	logic IRQ, sclk, mosi, miso;
	smf_cfg_t c;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 25478;
	int n_edge = 0;
	int half;
	realtime t_edge [2];

	initial
	begin
		forever #(CLK_PERIOD_NS / 2) CLK_SYS = ~CLK_SYS;
	end

	smf_top dut_u (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR),
		.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
		.IRQ(IRQ), .MASTER_SERIAL_CLOCK(sclk), .MASTER_SERIAL_OUT(mosi),
		.MASTER_SERIAL_IN(miso));

	smf_slave_model slave_u (.clk(CLK_SYS), .sel(sel), .cpol(c.sclk_idle_level),
		.cpha(c.sample_edge_select), .lsb(c.bit_order_select), .tx_byte(sb),
		.master_serial_clock(sclk), .master_serial_out(mosi), .master_serial_in(miso),
		.rx_byte(srx));

	always @(sclk)
	begin
		if (RESET_N === 1'b1)
		begin
			if (n_edge < 2)
				t_edge[n_edge] = $realtime;
			n_edge++;
		end
	end

	task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Half period in system clocks; codes past the largest fold onto it
	function automatic int exp_half(input logic [2:0] s);
		return 1 << ((s > DIV_SEL_MAX) ? int'(DIV_SEL_MAX) : int'(s));
	endfunction

	function automatic logic [7:0] exp_irq(input logic [3:0] st, input logic [3:0] m);
		return {7'h0, |(st & ~m)};
	endfunction

	// One strobe cycle; read data is taken one edge later
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge CLK_SYS);
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		SFR_WR <= w;
		SFR_RD <= !w;
		@(posedge CLK_SYS);
		SFR_WR <= 1'b0;
		SFR_RD <= 1'b0;
		#1 q = SFR_RDATA;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, d, 1'b1);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		acc(a, 8'h00, 1'b0);
		cmp("reg", exp, q);
	endtask

	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (80000) @(posedge CLK_SYS);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		c = '0;
		sb = 8'h00;
		repeat (4) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		@(posedge CLK_SYS);
		cmp("irq", 8'h00, {7'h0, IRQ});
		rd_chk(8'hfc, 8'h20);
		rd_chk(8'hfd, 8'h0f);
		rd_chk(8'hfe, 8'h03);
		rd_chk(8'hff, 8'h00);
		rd_chk(8'h10, 8'h00);
		wr(8'hfe, 8'hff);
		rd_chk(8'hfe, 8'h03);
		// Every mask code against flags 0011
		for (int m = 0; m < 16; m++)
		begin
			wr(8'hfd, 8'(m));
			cmp("irq", exp_irq(4'h3, 4'(m)), {7'h0, IRQ});
		end
		// All four modes, both bit orders, random and folded divider codes
		for (int i = 0; i < 10; i++)
		begin
			c.sclk_divider_select = (i < 8) ? 3'({$random(seed)} % 6) : 3'(i - 2);
			c.bit_order_select = i[2];
			c.sclk_idle_level = i[1];
			c.sample_edge_select = i[0];
			c.master_core_on = 1'b0;
			half = exp_half(c.sclk_divider_select);
			wr(8'hfc, {1'b0, c});
			rd_chk(8'hfc, {1'b0, c});
			b0 = 8'($random(seed));
			b1 = 8'($random(seed));
			sb = 8'($random(seed));
			sel <= 1'b1;
			n_edge = 0;
			// Preload while disabled; the third byte meets a full buffer
			wr(8'hff, b0);
			wr(8'hff, b1);
			wr(8'hff, ~b0);
			rd_chk(8'hfe, 8'h00);
			repeat (40) @(posedge CLK_SYS);
			cmp("edges", 8'h00, 8'(n_edge));
			c.master_core_on = 1'b1;
			wr(8'hfc, {1'b0, c});
			repeat (3000)
			begin
				acc(8'hfe, 8'h00, 1'b0);
				if (q[3] === 1'b1)
					break;
			end
			cmp("flags", 8'h0f, q);
			wr(8'hfd, 8'h07);
			cmp("irq", exp_irq(4'hf, 4'h7), {7'h0, IRQ});
			wr(8'hfd, 8'h0f);
			rd_chk(8'hff, sb);
			rd_chk(8'hff, ~sb);
			rd_chk(8'hfe, 8'h03);
			cmp("slave_rx", b1, srx);
			cmp("edges", 8'h20, 8'(n_edge));
			cmp("half", 8'(half), 8'(int'((t_edge[1] - t_edge[0]) / CLK_PERIOD_NS)));
			cmp("idle", {7'h0, c.sclk_idle_level}, {7'h0, sclk});
			sel <= 1'b0;
		end
		// Reset after the last transfer must bring config, mask, status and read data back
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		cmp("rdata", 8'h00, SFR_RDATA);
		RESET_N <= 1'b1;
		rd_chk(8'hfc, 8'h20);
		rd_chk(8'hfd, 8'h0f);
		rd_chk(8'hfe, 8'h03);
		give_verdict();
	end
endmodule
